/* include/adc_seq_pkg.sv */
// Purpose: shared constants and carrier types for the converter sequencer
// Assumes: byte-wide internal bus, 20-bit low address, one 250 MHz clock
// Notes: conversion lengths are counted in system clock states
`default_nettype none
package adc_seq_pkg;
	// ==========================================================
	// register addresses (low 20 bits)
	localparam logic [19:0] RESULT_A_HIGH_ADDR = 20'hFFFE0;
	localparam logic [19:0] RESULT_A_LOW_ADDR = 20'hFFFE1;
	localparam logic [19:0] RESULT_B_HIGH_ADDR = 20'hFFFE2;
	localparam logic [19:0] RESULT_B_LOW_ADDR = 20'hFFFE3;
	localparam logic [19:0] RESULT_C_HIGH_ADDR = 20'hFFFE4;
	localparam logic [19:0] RESULT_C_LOW_ADDR = 20'hFFFE5;
	localparam logic [19:0] RESULT_D_HIGH_ADDR = 20'hFFFE6;
	localparam logic [19:0] RESULT_D_LOW_ADDR = 20'hFFFE7;
	localparam logic [19:0] CONV_CONTROL_STATUS_ADDR = 20'hFFFE8;
	localparam logic [19:0] TRIGGER_CONTROL_ADDR = 20'hFFFE9;
	// ==========================================================
	// reset values and fixed fields
	localparam logic [7:0] CONV_CONTROL_STATUS_RESET = 8'h00;
	localparam logic [7:0] TRIGGER_CONTROL_RESET = 8'h7E;
	localparam logic [5:0] TRIGGER_FIXED_ONES = 6'h3F;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [5:0] RESULT_PAD = 6'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int RESULT_WIDTH = 10;
	localparam int RESULT_COUNT = 4;
	// ==========================================================
	// conversion timing, in system clock states
	localparam logic [3:0] SAMPLE_FAST = 4'hA;
	localparam logic [3:0] BIT_FAST = 4'h6;
	localparam logic [3:0] SAMPLE_SLOW = 4'hE;
	localparam logic [3:0] BIT_SLOW = 4'hC;
	localparam int CONV_FAST_STATES = 70;
	localparam int CONV_SLOW_STATES = 134;
	localparam int CONV_MAX_NS = 3500;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic conversion_end_flag;
		logic end_irq_enable;
		logic conversion_start_bit;
		logic scan_mode;
		logic fast_clock;
		logic group_select_bit;
		logic channel_select_hi;
		logic channel_select_lo;
	} conv_csr_t;
	typedef struct packed {
		logic [19:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} cpu_req_t;
	typedef enum logic [1:0] {IDLE, SAMPLE, APPROX} seq_state_t;
endpackage
`default_nettype wire

/* rtl/adc_sequencer_result_regs.sv */
// Purpose: control, sequencing and result registers of a 10-bit SAR converter
// Assumes: comparator_high comes from same-clock logic; one byte access per strobe
// Notes: standby is a synchronous clear; module_stop halts without clearing
`default_nettype none
module adc_sequencer_result_regs
	import adc_seq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic standby,
	input wire logic module_stop,
	input wire cpu_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	input wire logic dma_ack,
	input wire logic external_start_trigger,
	input wire logic timer_compare_match,
	input wire logic comparator_high,
	output logic [2:0] analog_channel,
	output logic [9:0] trial_code,
	output logic sample_hold,
	output logic conversion_end_irq,
	output logic dma_request
);
	// ==========================================================
	// state
	conv_csr_t csr;
	logic hw_trigger_enable;
	logic trig_spare;
	logic [RESULT_WIDTH-1:0] results [RESULT_COUNT];
	logic [7:0] temp_low;
	logic flag_armed;
	seq_state_t state;
	seq_state_t next_state;
	logic [3:0] step_cnt;
	logic [3:0] bit_idx;
	logic trig_meta;
	logic trig_sync;
	logic trig_prev;
	logic [7:0] conv_age;

	// ==========================================================
	// bus decode
	wire result_hit = cpu_req.addr[19:3] == RESULT_A_HIGH_ADDR[19:3];
	wire [1:0] result_idx = cpu_req.addr[2:1];
	wire result_low = cpu_req.addr[0];
	wire csr_hit = cpu_req.addr == CONV_CONTROL_STATUS_ADDR;
	wire trig_hit = cpu_req.addr == TRIGGER_CONTROL_ADDR;
	wire csr_write = cpu_req.wr & csr_hit;
	wire trig_write = cpu_req.wr & trig_hit;
	wire conv_csr_t wr_csr = conv_csr_t'(cpu_req.wdata);
	wire high_read = cpu_req.rd & result_hit & ~result_low;
	wire [7:0] trig_view = {hw_trigger_enable, TRIGGER_FIXED_ONES, trig_spare};
	// lower byte comes from the holding register, never the live result
	wire [7:0] result_view = result_low ? temp_low : results[result_idx][9:2];
	wire [7:0] read_mux = result_hit ? result_view :
		csr_hit ? 8'(csr) :
		trig_hit ? trig_view : UNMAPPED_READ;

	// ==========================================================
	// start sources
	wire trig_fall = trig_prev & ~trig_sync;
	wire hw_start = hw_trigger_enable & (trig_fall | timer_compare_match) & ~module_stop;

	// ==========================================================
	// sequencer decode
	wire [3:0] sample_len = csr.fast_clock ? SAMPLE_FAST : SAMPLE_SLOW;
	wire [3:0] bit_len = csr.fast_clock ? BIT_FAST : BIT_SLOW;
	// only bit steps wrap on the bit length; the sample phase runs its own full length
	wire step_end = state == APPROX && step_cnt == bit_len - 4'h1;
	wire sample_end = state == SAMPLE && step_cnt == sample_len - 4'h1;
	wire conv_done = state == APPROX && step_end && bit_idx == 4'h0;
	wire [1:0] run_end = {csr.channel_select_hi, csr.channel_select_lo};
	// group bit chooses inputs 0-3 or 4-7
	wire [2:0] first_chan = csr.scan_mode ? {csr.group_select_bit, 2'b00} :
		{csr.group_select_bit, run_end};
	wire last_chan = ~csr.scan_mode | analog_channel[1:0] == run_end;
	wire [2:0] following_chan = last_chan ? first_chan : analog_channel + 3'h1;
	wire [9:0] final_code = {trial_code[9:1], comparator_high};
	wire abort = ~csr.conversion_start_bit | module_stop;
	// an aborted pass stores nothing, so it must not raise the flag either
	wire flag_set = conv_done & last_chan & ~abort;
	wire flag_clear = (csr_write & ~wr_csr.conversion_end_flag & flag_armed) | dma_ack;
	wire single_end = conv_done & ~csr.scan_mode;

	// ==========================================================
	// next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			IDLE:
				if (csr.conversion_start_bit && !module_stop)
					next_state = SAMPLE;
			SAMPLE:
				if (abort)
					next_state = IDLE;
				else if (sample_end)
					next_state = APPROX;
			APPROX:
				if (abort)
					next_state = IDLE;
				else if (conv_done)
					next_state = csr.scan_mode ? SAMPLE : IDLE;
		endcase
	end

	// ==========================================================
	// trigger pin synchroniser
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			trig_meta <= 1'b1;
			trig_sync <= 1'b1;
			trig_prev <= 1'b1;
		end
		else
		begin
			trig_meta <= external_start_trigger;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end

	// ==========================================================
	// control and status register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
			csr <= conv_csr_t'(CONV_CONTROL_STATUS_RESET);
		else
		begin
			if (csr_write)
				csr[6:0] <= wr_csr[6:0];
			else if (hw_start)
				csr.conversion_start_bit <= 1'b1;
			else if (single_end || module_stop)
				csr.conversion_start_bit <= 1'b0;
			// a finishing conversion wins over a clear in the same cycle
			csr.conversion_end_flag <= flag_set |
				(csr.conversion_end_flag & ~flag_clear);
		end
	end

	// the flag must have been seen as one before a zero write clears it
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
			flag_armed <= 1'b0;
		else if (!csr.conversion_end_flag || csr_write)
			flag_armed <= 1'b0;
		else if (cpu_req.rd && csr_hit)
			flag_armed <= 1'b1;
	end

	// ==========================================================
	// trigger control register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
		begin
			hw_trigger_enable <= TRIGGER_CONTROL_RESET[7];
			trig_spare <= TRIGGER_CONTROL_RESET[0];
		end
		else if (trig_write)
		begin
			hw_trigger_enable <= cpu_req.wdata[7];
			trig_spare <= cpu_req.wdata[0];
		end
	end

	// ==========================================================
	// result registers: only the sequencer writes them
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
		begin
			for (int i = 0; i < RESULT_COUNT; i++)
				results[i] <= RESULT_RESET;
		end
		else if (conv_done && !abort)
			results[analog_channel[1:0]] <= final_code;
	end

	// ==========================================================
	// read path and holding register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
		begin
			cpu_rdata <= UNMAPPED_READ;
			temp_low <= UNMAPPED_READ;
		end
		else if (cpu_req.rd)
		begin
			cpu_rdata <= read_mux;
			if (high_read)
				temp_low <= {results[result_idx][1:0], RESULT_PAD};
		end
	end

	// ==========================================================
	// successive approximation
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || standby)
		begin
			state <= IDLE;
			step_cnt <= 4'h0;
			bit_idx <= 4'h0;
			trial_code <= RESULT_RESET;
			analog_channel <= 3'h0;
		end
		else
		begin
			state <= next_state;
			if (state == IDLE || next_state != state || step_end)
				step_cnt <= 4'h0;
			else
				step_cnt <= step_cnt + 4'h1;
			if (state == IDLE)
				analog_channel <= first_chan;
			else if (conv_done)
				analog_channel <= following_chan;
			if (next_state == APPROX && state == SAMPLE)
			begin
				bit_idx <= 4'h9;
				trial_code <= 10'h200;
			end
			else if (state == APPROX && step_end && bit_idx != 4'h0)
			begin
				trial_code[bit_idx] <= comparator_high;
				trial_code[bit_idx - 4'h1] <= 1'b1;
				bit_idx <= bit_idx - 4'h1;
			end
		end
	end

	assign sample_hold = state == SAMPLE;
	assign conversion_end_irq = csr.conversion_end_flag & csr.end_irq_enable;
	assign dma_request = csr.conversion_end_flag;

	// ==========================================================
	// checks
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			conv_age <= 8'h00;
		else if (state == IDLE || conv_done)
			conv_age <= 8'h00;
		else
			conv_age <= conv_age + 8'h01;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	low_pad_zero_a: assert property (cpu_req.rd && result_hit && result_low && !standby
		|=> cpu_rdata[5:0] == 6'h00)
		else $error("lower result byte has nonzero pad bits");
	flag_on_end_a: assert property (conv_done && last_chan && !abort && !standby
		|=> csr.conversion_end_flag)
		else $error("end flag not set after conversion");
	no_flag_by_write_a: assert property (!csr.conversion_end_flag && !flag_set
		|=> !csr.conversion_end_flag)
		else $error("end flag set without a conversion end");
	single_stop_a: assert property (single_end && !csr_write && !hw_start && !standby
		|=> !csr.conversion_start_bit ##1 state == IDLE)
		else $error("single mode did not stop");
	fast_time_a: assert property (conv_done && csr.fast_clock
		|-> conv_age == 8'(CONV_FAST_STATES - 1))
		else $error("fast conversion length wrong");
	route_result_a: assert property (conv_done && !abort && !standby
		|=> results[$past(analog_channel[1:0])] == $past(final_code))
		else $error("result went to the wrong register");
	standby_clear_a: assert property (standby
		|=> results[0] == RESULT_RESET && results[3] == RESULT_RESET && 8'(csr) == 8'h00)
		else $error("standby did not clear registers");
	result_ro_a: assert property (cpu_req.wr && result_hit && !conv_done && !standby
		|=> $stable(results[0]) && $stable(results[3]))
		else $error("write changed a result register");
	hold_low_a: assert property (high_read && !standby ##[1:2] cpu_req.rd && result_hit
		&& result_low && !standby |=> cpu_rdata == $past(temp_low))
		else $error("lower byte not served from holding register");
	scan_keeps_a: assert property (conv_done && csr.scan_mode && !abort && !csr_write
		&& !standby |=> csr.conversion_start_bit && state == SAMPLE)
		else $error("scan mode stopped on its own");
	irq_follow_a: assert property ($rose(csr.conversion_end_flag) && csr.end_irq_enable
		|-> conversion_end_irq && dma_request)
		else $error("end request missing");
endmodule
`default_nettype wire

/* tb/adc_comparator_model.sv */
// Purpose: ideal analog comparator array facing the converter sequencer
// Assumes: eight fixed input levels given as 10-bit codes by the bench
// Notes: answers at once; a real comparator settles within the bit step anyway
`default_nettype none
module adc_comparator_model
	import adc_seq_pkg::*;
(
	input wire logic [2:0] analog_channel,
	input wire logic [9:0] trial_code,
	input wire logic [79:0] levels,
	output logic comparator_high
);
	// ==========================================================
	// input selection and compare
	// top channel bit picks the group of four, low bits the input in it
	wire logic [9:0] selected_level = levels[analog_channel * 10 +: 10];
	assign comparator_high = (selected_level >= trial_code);
endmodule
`default_nettype wire

/* tb/test_adc_sequencer_result_regs.sv */
// Purpose: register-level test of the converter sequencer
// Assumes: one byte access per request; conversions timed from the start write
// Notes: expected results come from the bench's own level table
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
	$display("CHECK FAILED at %0t got %h expected %h", $time, (got), (exp)); \
	n_mismatch++; end end
module test_adc_sequencer_result_regs
	import adc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, rst, standby, module_stop, dma_ack, ext_trig, tmr_match, cmp_high;
	cpu_req_t req;
	logic [7:0] rdata;
	logic [2:0] chan;
	logic [9:0] trial;
	logic [79:0] levels;
	logic irq, dma_req;
	int n_mismatch = 0;
	int samples_checked = 0;
	localparam logic [19:0] CSR = CONV_CONTROL_STATUS_ADDR;
	localparam logic [19:0] TRG = TRIGGER_CONTROL_ADDR;
	adc_sequencer_result_regs adc_sequencer_result_regs_i (.ref_clk(ref_clk), .rst(rst),
		.standby(standby), .module_stop(module_stop), .cpu_req(req), .cpu_rdata(rdata),
		.dma_ack(dma_ack), .external_start_trigger(ext_trig),
		.timer_compare_match(tmr_match), .comparator_high(cmp_high), .analog_channel(chan),
		.trial_code(trial), .sample_hold(), .conversion_end_irq(irq), .dma_request(dma_req));
	adc_comparator_model adc_comparator_model_i (.analog_channel(chan), .trial_code(trial),
		.levels(levels), .comparator_high(cmp_high));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// bus tasks
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(posedge ref_clk);
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// a lost end flag must not hang the run
	task automatic wait_flag(output int n);
		n = 0;
		#1;
		while (dma_req !== 1'b1 && n < 1000)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 1000)
		begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic pulse_dma();
		@(posedge ref_clk);
		dma_ack <= 1'b1;
		@(posedge ref_clk);
		dma_ack <= 1'b0;
	endtask
	task automatic chk_idle();
		for (int i = 0; i < 8; i++)
			rd_chk(RESULT_A_HIGH_ADDR + 20'(i), 8'h00);
		rd_chk(CSR, CONV_CONTROL_STATUS_RESET);
		rd_chk(TRG, TRIGGER_CONTROL_RESET);
	endtask
	task automatic chk_result(input logic [2:0] ch);
		logic [9:0] lv;
		lv = levels[ch * 10 +: 10];
		rd_chk(RESULT_A_HIGH_ADDR + 20'({ch[1:0], 1'b0}), lv[9:2]);
		rd_chk(RESULT_A_LOW_ADDR + 20'({ch[1:0], 1'b0}), {lv[1:0], RESULT_PAD});
	endtask
	// ==========================================================
	// one single-mode conversion, cleared by software or by the DMA side
	task automatic conv(input logic [2:0] ch, input logic fast, input logic ie, input logic dm);
		int n;
		int lim;
		lim = fast ? CONV_FAST_STATES : CONV_SLOW_STATES;
		wr(CSR, {1'b0, ie, 1'b1, 1'b0, fast, ch});
		wait_flag(n);
		`CHK(n inside {[lim - 2 : lim + 4]}, 1'b1)
		`CHK(irq, ie)
		rd_chk(CSR, {1'b1, ie, 2'b00, fast, ch});
		chk_result(ch);
		if (dm)
			pulse_dma();
		else
			wr(CSR, {1'b0, ie, 2'b00, fast, ch});
		rd_chk(CSR, {1'b0, ie, 2'b00, fast, ch});
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		int n;
		rst = 1'b1;
		standby = 1'b0;
		module_stop = 1'b0;
		dma_ack = 1'b0;
		ext_trig = 1'b1;
		tmr_match = 1'b0;
		req = '0;
		levels = {10'h2AA, 10'h155, 10'h0FF, 10'h200, 10'h001, 10'h3FF, 10'h13C, 10'h2A5};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		chk_idle();
		for (int i = 0; i < 8; i++)
			wr(RESULT_A_HIGH_ADDR + 20'(i), 8'hFF);
		chk_idle();
		rd_chk(20'hFFFEA, UNMAPPED_READ);
		for (int c = 0; c < 8; c++)
			conv(3'(c), c != 5, c[0], c[2]);
		repeat (200) @(posedge ref_clk);
		`CHK(dma_req, 1'b0)
		wr(CSR, 8'h80);
		rd_chk(CSR, 8'h00);
		// scan over inputs 4 to 6; register D keeps the input 7 result
		wr(CSR, 8'h3E);
		wait_flag(n);
		`CHK(n inside {[3 * CONV_FAST_STATES - 2 : 3 * CONV_FAST_STATES + 12]}, 1'b1)
		rd_chk(CSR, 8'hBE);
		for (int c = 4; c < 8; c++)
			chk_result(3'(c));
		wr(CSR, 8'h1E);
		rd_chk(CSR, 8'h1E);
		// hardware start sources
		wr(TRG, 8'h80);
		rd_chk(TRG, 8'hFE);
		wr(CSR, 8'h09);
		@(posedge ref_clk);
		tmr_match <= 1'b1;
		@(posedge ref_clk);
		tmr_match <= 1'b0;
		wait_flag(n);
		rd_chk(CSR, 8'h89);
		pulse_dma();
		@(posedge ref_clk);
		ext_trig <= 1'b0;
		wait_flag(n);
		rd_chk(CSR, 8'h89);
		pulse_dma();
		@(posedge ref_clk);
		ext_trig <= 1'b1;
		wr(TRG, 8'h00);
		rd_chk(TRG, TRIGGER_CONTROL_RESET);
		@(posedge ref_clk);
		tmr_match <= 1'b1;
		@(posedge ref_clk);
		tmr_match <= 1'b0;
		repeat (200) @(posedge ref_clk);
		`CHK(dma_req, 1'b0)
		// stopped converter ignores a start
		module_stop <= 1'b1;
		wr(CSR, 8'h28);
		repeat (200) @(posedge ref_clk);
		`CHK(dma_req, 1'b0)
		wr(CSR, 8'h00);
		module_stop <= 1'b0;
		wr(TRG, 8'h80);
		@(posedge ref_clk);
		standby <= 1'b1;
		repeat (2) @(posedge ref_clk);
		standby <= 1'b0;
		chk_idle();
		complete_run();
	end
endmodule
`default_nettype wire
